/* File: lane_mode_pkg.sv */
// constants, field layouts and carrier types for the lane mode pixel distributor
// assumes a 20 MHz system clock and a slow recovered pixel clock sampled as data
package lane_mode_pkg;

  // -------------------------------------------------------------------
  // register map, byte offsets on an 8-bit register port
  // -------------------------------------------------------------------
  localparam logic [7:0] ADDR_LINK = 8'h23;
  localparam logic [7:0] ADDR_LANE = 8'h34;
  localparam logic [7:0] ADDR_STAT = 8'h35;
  localparam logic [7:0] ADDR_PMAX = 8'h36;
  localparam logic [7:0] ADDR_PMIN = 8'h37;
  localparam logic [7:0] ADDR_OUT = 8'h49;

  // field positions
  localparam int LINK_LVL_LSB = 2;
  localparam int LINK_FAST_BIT = 3;
  localparam int LINK_COAX_BIT = 2;
  localparam int LANE_OVR_LSB = 3;
  localparam int OUT_MAP_BIT = 2;
  localparam int OUT_B24_BIT = 3;

  // values after reset
  localparam logic [7:0] LINK_RST = 8'h00;
  localparam logic [7:0] LANE_RST = 8'h00;
  localparam logic [7:0] OUT_RST = 8'h08;

  // output format and lane override codes
  localparam logic [1:0] FMT_DUAL = 2'h0;
  localparam logic [1:0] FMT_SWAP = 2'h1;
  localparam logic [1:0] FMT_SINGLE = 2'h2;
  localparam logic [1:0] FMT_REPL = 2'h3;
  localparam logic [1:0] LANE_FORCE1 = 2'h1;
  localparam logic [1:0] LANE_FORCE2 = 2'h2;

  // output clock rate codes, relative to the pixel clock
  localparam logic [1:0] RATE_OFF = 2'h0;
  localparam logic [1:0] RATE_HALF = 2'h1;
  localparam logic [1:0] RATE_SAME = 2'h2;
  localparam logic [1:0] RATE_DOUBLE = 2'h3;

  // pixel clock limits in MHz
  localparam logic [7:0] PCLK_MAX_SINGLE = 8'd96;
  localparam logic [7:0] PCLK_MAX_DUAL = 8'd192;
  localparam logic [7:0] PCLK_MIN_1L_SINGLE = 8'd25;
  localparam logic [7:0] PCLK_MIN_OTHER = 8'd50;

  // widths and the 2-high 3-low 2-high clock shape of one frame
  localparam int SYM_W = 35;
  localparam int FRAME_W = 28;
  localparam int LANE_BITS = 7;
  localparam logic [6:0] CLK_PAT = 7'h63;
  localparam logic [1:0] STRAP_WAIT = 2'h2;

  typedef enum logic {PH_ODD, PH_EVEN} phase_t;

  typedef struct packed {
    logic de;
    logic vs;
    logic hs;
    logic [23:0] rgb;
  } pixel_t;

  typedef struct packed {
    logic [FRAME_W-1:0] odd;
    logic [FRAME_W-1:0] even;
    logic strobe;
    logic [6:0] first_output_clock_pat;
    logic [6:0] second_output_clock_pat;
    logic [1:0] first_output_clock_rate;
    logic [1:0] second_output_clock_rate;
  } lvds_out_t;

  typedef struct packed {
    logic map_sel;
    logic bpp24;
    logic fast_bc;
    logic coax;
    logic two_lanes;
  } cfg_t;

  typedef struct packed {
    logic pclk_m;
    logic pclk_s;
    logic pclk_d;
    logic [SYM_W-1:0] l0_m;
    logic [SYM_W-1:0] l0_s;
    logic [SYM_W-1:0] l1_m;
    logic [SYM_W-1:0] l1_s;
    logic l1ok_m;
    logic l1ok_s;
    logic [2:0] out_m;
    logic [2:0] out_s;
    logic [2:0] link_m;
    logic [2:0] link_s;
    logic [1:0] strap_cnt;
    logic strap_done;
    logic [7:0] link_reg;
    logic [7:0] lane_reg;
    logic [7:0] out_reg;
    logic [7:0] rdata;
    logic [7:0] pmax;
    logic [7:0] pmin;
    phase_t phase;
    logic de_d;
    logic [FRAME_W-1:0] hold;
    logic [FRAME_W-1:0] pend_frame;
    logic pend;
    lvds_out_t out;
    cfg_t cfg;
  } state_t;

endpackage : lane_mode_pkg

/* File: lane_mode_pixel_distributor.sv */
// lane mode pixel distributor: strap and register mode select, pixel routing
// assumes pixel clock and lane symbols arrive from another domain, slow vs clk
//
// The plain strobed port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps

module lane_mode_pixel_distributor (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // recovered pixel stream
  input wire logic pclk_in,
  input wire logic [lane_mode_pkg::SYM_W-1:0] lane0_symbol,
  input wire logic [lane_mode_pkg::SYM_W-1:0] lane1_symbol,
  input wire logic lane1_present,
  // straps
  input wire logic [2:0] output_mode_strap,
  input wire logic [2:0] link_mode_strap,
  // register port
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  // display side
  output lane_mode_pkg::lvds_out_t lvds_display_output,
  output lane_mode_pkg::cfg_t cfg
);
  import lane_mode_pkg::*;
  state_t r, n;

  // -------------------------------------------------------------------
  // colour packing into one 28-bit frame
  // -------------------------------------------------------------------
  // with b24 set, msb3 high puts the colour msbs on the fourth lane, low puts lsbs there; b24 clear puts zeros there
  function automatic logic [FRAME_W-1:0] pack_frame(pixel_t p, logic b24,
                                                    logic msb3);
    logic hi;
    logic [5:0] r6, g6, b6;
    logic [1:0] rx, gx, bx;
    hi = b24 && msb3;
    r6 = hi ? p.rgb[21:16] : p.rgb[23:18];
    g6 = hi ? p.rgb[13:8] : p.rgb[15:10];
    b6 = hi ? p.rgb[5:0] : p.rgb[7:2];
    rx = hi ? p.rgb[23:22] : (b24 ? p.rgb[17:16] : 2'h0);
    gx = hi ? p.rgb[15:14] : (b24 ? p.rgb[9:8] : 2'h0);
    bx = hi ? p.rgb[7:6] : (b24 ? p.rgb[1:0] : 2'h0);
    return {1'b0, rx, gx, bx, p.de, p.vs, p.hs, b6, g6, r6};
  endfunction : pack_frame

  // -------------------------------------------------------------------
  // mode decode from the live registers
  // -------------------------------------------------------------------
  logic [1:0] fmt;
  logic two, dual, swap, repl, pedge, rise;
  pixel_t p0, p1;
  logic [FRAME_W-1:0] f0, f1;

  always_comb
  begin
    fmt = r.out_reg[1:0];
    dual = (fmt == FMT_DUAL) || (fmt == FMT_SWAP);
    swap = (fmt == FMT_SWAP);
    repl = (fmt == FMT_REPL);
    case (r.lane_reg[LANE_OVR_LSB+:2])
      LANE_FORCE1: two = 1'b0;
      LANE_FORCE2: two = 1'b1;
      default: two = r.l1ok_s;
    endcase
    // pixel fields sit in the low bits of each recovered symbol
    p0 = pixel_t'(r.l0_s[26:0]);
    p1 = pixel_t'(r.l1_s[26:0]);
    f0 = pack_frame(p0, r.out_reg[OUT_B24_BIT], r.out_reg[OUT_MAP_BIT]);
    f1 = pack_frame(p1, r.out_reg[OUT_B24_BIT], r.out_reg[OUT_MAP_BIT]);
    pedge = r.pclk_s && !r.pclk_d;
    rise = p0.de && !r.de_d;
  end

  // -------------------------------------------------------------------
  // next state
  // -------------------------------------------------------------------
  always_comb
  begin
    n = r;
    n.out.strobe = 1'b0;
    n.rdata = 8'h00;
    // two flops on every foreign input
    n.pclk_m = pclk_in;
    n.pclk_s = r.pclk_m;
    n.pclk_d = r.pclk_s;
    n.l0_m = lane0_symbol;
    n.l0_s = r.l0_m;
    n.l1_m = lane1_symbol;
    n.l1_s = r.l1_m;
    n.l1ok_m = lane1_present;
    n.l1ok_s = r.l1ok_m;
    n.out_m = output_mode_strap;
    n.out_s = r.out_m;
    n.link_m = link_mode_strap;
    n.link_s = r.link_m;

    // straps caught once, after the synchronisers have filled
    if (!r.strap_done)
    begin
      n.strap_cnt = r.strap_cnt + 2'h1;
      if (r.strap_cnt == STRAP_WAIT)
      begin
        n.strap_done = 1'b1;
        n.link_reg[LINK_LVL_LSB+:3] = r.link_s;
        n.out_reg[2:0] = r.out_s;
      end
    end

    // a write in the capture cycle still wins over the strap
    if (wr)
    begin
      case (addr)
        ADDR_LINK: n.link_reg = wdata;
        ADDR_LANE: n.lane_reg = wdata;
        ADDR_OUT: n.out_reg = wdata;
        default: ;
      endcase
    end
    if (rd)
    begin
      case (addr)
        ADDR_LINK: n.rdata = r.link_reg;
        ADDR_LANE: n.rdata = r.lane_reg;
        ADDR_OUT: n.rdata = r.out_reg;
        ADDR_STAT: n.rdata = {3'h0, r.out.second_output_clock_rate, r.out.first_output_clock_rate,
                              r.cfg.two_lanes};
        ADDR_PMAX: n.rdata = r.pmax;
        ADDR_PMIN: n.rdata = r.pmin;
        default: n.rdata = 8'h00;
      endcase
    end

    n.cfg.map_sel = r.out_reg[OUT_MAP_BIT];
    n.cfg.bpp24 = r.out_reg[OUT_B24_BIT];
    n.cfg.fast_bc = r.link_reg[LINK_FAST_BIT];
    n.cfg.coax = r.link_reg[LINK_COAX_BIT];
    n.cfg.two_lanes = two;

    // output clock rates and allowed pixel clock range per path
    if (dual)
    begin
      n.out.first_output_clock_rate = RATE_HALF;
      n.out.second_output_clock_rate = RATE_HALF;
      n.pmax = two ? PCLK_MAX_DUAL : PCLK_MAX_SINGLE;
      n.pmin = PCLK_MIN_OTHER;
    end
    else if (two && !repl)
    begin
      n.out.first_output_clock_rate = RATE_DOUBLE;
      n.out.second_output_clock_rate = RATE_OFF;
      n.pmax = PCLK_MAX_DUAL;
      n.pmin = PCLK_MIN_OTHER;
    end
    else
    begin
      n.out.first_output_clock_rate = RATE_SAME;
      n.out.second_output_clock_rate = repl ? RATE_SAME : RATE_OFF;
      n.pmax = PCLK_MAX_SINGLE;
      n.pmin = PCLK_MIN_1L_SINGLE;
    end
    n.out.first_output_clock_pat = (n.out.first_output_clock_rate != RATE_OFF) ? CLK_PAT : 7'h00;
    n.out.second_output_clock_pat = (n.out.second_output_clock_rate != RATE_OFF) ? CLK_PAT : 7'h00;

    // pixel routing, one decision per pixel clock edge
    if (pedge)
    begin
      n.de_d = p0.de;
      n.pend = 1'b0;
      if (dual && two)
      begin
        n.out.odd = swap ? f1 : f0;
        n.out.even = swap ? f0 : f1;
        n.out.strobe = 1'b1;
        n.phase = PH_ODD;
      end
      else if (dual)
      begin
        // split restarts at each rise of active video
        if (rise || r.phase == PH_ODD)
        begin
          n.hold = f0;
          n.phase = PH_EVEN;
        end
        else
        begin
          n.out.odd = swap ? f0 : r.hold;
          n.out.even = swap ? r.hold : f0;
          n.out.strobe = 1'b1;
          n.phase = PH_ODD;
        end
      end
      else
      begin
        n.out.odd = f0;
        n.out.even = repl ? f0 : {FRAME_W{1'b0}};
        n.out.strobe = 1'b1;
        n.phase = PH_ODD;
        if (two && !repl)
        begin
          // second lane's pixel follows in the next frame slot
          n.pend = 1'b1;
          n.pend_frame = f1;
        end
      end
    end
    else if (r.pend)
    begin
      n.out.odd = r.pend_frame;
      n.out.even = {FRAME_W{1'b0}};
      n.out.strobe = 1'b1;
      n.pend = 1'b0;
    end
  end

  // -------------------------------------------------------------------
  // state register
  // -------------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      r <= '0;
      r.link_reg <= LINK_RST;
      r.lane_reg <= LANE_RST;
      r.out_reg <= OUT_RST;
      r.phase <= PH_ODD;
    end
    else
    begin
      r <= n;
    end
  end
  assign rdata = r.rdata;
  assign lvds_display_output = r.out;
  assign cfg = r.cfg;

  // -------------------------------------------------------------------
  // checks
  // -------------------------------------------------------------------
  property p_strap_load;
    @(posedge clk) disable iff (reset)
      $rose(r.strap_done) && !$past(wr) |-> r.out_reg[2:0] == $past(r.out_s)
        && r.link_reg[4:2] == $past(r.link_s);
  endproperty
  a_strap_load: assert property (p_strap_load)
    else $error("straps not captured on release");
  property p_strap_once;
    @(posedge clk) disable iff (reset)
      r.strap_done && !wr |=> $stable(r.out_reg) && $stable(r.link_reg);
  endproperty
  a_strap_once: assert property (p_strap_once)
    else $error("mode changed without a write");
  property p_lane_force;
    @(posedge clk) disable iff (reset)
      r.lane_reg[4:3] == LANE_FORCE1 && !wr |=> ##1 !r.cfg.two_lanes;
  endproperty
  a_lane_force: assert property (p_lane_force)
    else $error("lane override ignored");
  property p_dual_clk;
    @(posedge clk) disable iff (reset)
      r.out_reg[1] == 1'b0 && !wr [*2] |=> r.out.first_output_clock_rate == RATE_HALF
        && r.out.second_output_clock_rate == RATE_HALF && r.out.second_output_clock_pat == CLK_PAT;
  endproperty
  a_dual_clk: assert property (p_dual_clk)
    else $error("dual link clocks not at half rate");
  property p_split_start;
    @(posedge clk) disable iff (reset)
      pedge && dual && !two && rise |=> r.phase == PH_EVEN && !r.out.strobe
        && r.hold == $past(f0);
  endproperty
  a_split_start: assert property (p_split_start)
    else $error("first active pixel not taken as odd");
  property p_odd_lanes;
    @(posedge clk) disable iff (reset)
      pedge && dual && !swap && !two && r.phase == PH_EVEN && !rise
        |=> r.out.strobe && r.out.odd == $past(r.hold) && r.out.even == $past(f0);
  endproperty
  a_odd_lanes: assert property (p_odd_lanes)
    else $error("odd/even lane groups misplaced");
  property p_swap;
    @(posedge clk) disable iff (reset)
      pedge && dual && swap && two |=> r.out.odd == $past(f1)
        && r.out.even == $past(f0);
  endproperty
  a_swap: assert property (p_swap)
    else $error("swapped mode did not exchange groups");
  property p_double_rate;
    @(posedge clk) disable iff (reset)
      pedge && !dual && two && !repl |=> r.out.strobe ##1 r.out.strobe
        && r.out.odd == $past(f1, 2);
  endproperty
  a_double_rate: assert property (p_double_rate)
    else $error("second lane frame missing");
  property p_replicate;
    @(posedge clk) disable iff (reset)
      r.out.strobe && r.out.second_output_clock_rate == RATE_SAME |-> r.out.even == r.out.odd;
  endproperty
  a_replicate: assert property (p_replicate)
    else $error("replicate copy differs");
  property p_clk_shape;
    @(posedge clk) disable iff (reset)
      r.out.first_output_clock_rate != RATE_OFF |-> r.out.first_output_clock_pat == 7'h63;
  endproperty
  a_clk_shape: assert property (p_clk_shape)
    else $error("output clock shape wrong");
  property p_read;
    @(posedge clk) disable iff (reset)
      rd && addr == ADDR_OUT && !$past(wr) |=> rdata == $past(r.out_reg, 1) ##1
        ($past(rd) || rdata == 8'h00);
  endproperty
  a_read: assert property (p_read)
    else $error("read data not in the cycle after the strobe");

endmodule : lane_mode_pixel_distributor

/* File: pixel_source.sv */
// serializer model: recovered pixel clock and both lane symbols
// assumes the bench calls send_pixel once per pixel; clock idles low between
`timescale 1ns/1ps
module pixel_source
  import lane_mode_pkg::*;
(
  // pixel link
  output logic pclk,
  output logic [lane_mode_pkg::SYM_W-1:0] sym0,
  output logic [lane_mode_pkg::SYM_W-1:0] sym1
);
  initial
  begin
    pclk = 1'h0;
    sym0 = 35'h0;
    sym1 = 35'h0;
  end

  // one symbol per lane per 400 ns period, off the system clock edges
  task automatic send_pixel(input logic [SYM_W-1:0] a, input logic [SYM_W-1:0] b);
    #7;
    sym0 = a;
    sym1 = b;
    #100 pclk = 1'h1;
    #200 pclk = 1'h0;
    // hold time over: stale symbols must not look valid
    #50;
    sym0 = ~a;
    sym1 = ~b;
    // symbols never change on a clock edge; the call still spans 400 ns
    #43;
  endtask : send_pixel
endmodule : pixel_source

/* File: lane_mode_pixel_distributor_tb.sv */
// self-checking bench for the lane mode pixel distributor
// assumes pixel_source drives the pixel link; bench owns straps and registers
`timescale 1ns/1ps
module lane_mode_pixel_distributor_tb;
  import lane_mode_pkg::*;

  typedef struct packed {
    logic [7:0] out_val;
    logic [7:0] lane_val;
    logic l1p;
    logic [1:0] r1;
    logic [1:0] r2;
    logic two;
    logic chk2;
    logic [2:0] n;
    logic [15:0] od;
    logic [15:0] ev;
    logic [7:0] pmax;
    logic [7:0] pmin;
  } row_t;

  logic clk;
  logic reset;
  logic pclk_in;
  logic lane1_present;
  logic wr;
  logic rd;
  logic [SYM_W-1:0] lane0_symbol;
  logic [SYM_W-1:0] lane1_symbol;
  logic [2:0] output_mode_strap;
  logic [2:0] link_mode_strap;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  lvds_out_t lvds_display_output;
  cfg_t cfg;
  int error_cnt;
  int total_checks;
  logic [FRAME_W-1:0] q_odd[$];
  logic [FRAME_W-1:0] q_even[$];
  logic [FRAME_W-1:0] fr[5];
  logic [SYM_W-1:0] pix[4] = '{35'h4c3a51e, 35'h65a7f81, 35'h50ff0aa, 35'h4e1327c};
  row_t r;
  // nibbles of od/ev pick pixel 0..3, 4 means zero
  row_t rows[11] = '{
    '{8'h0a, 8'h08, 1'h1, RATE_SAME, RATE_OFF, 1'h0, 1'h1, 3'h2, 16'h0244, 16'h4444, 8'h60, 8'h19},
    '{8'h0e, 8'h08, 1'h0, RATE_SAME, RATE_OFF, 1'h0, 1'h1, 3'h2, 16'h0244, 16'h4444, 8'h60, 8'h19},
    '{8'h02, 8'h08, 1'h0, RATE_SAME, RATE_OFF, 1'h0, 1'h1, 3'h2, 16'h0244, 16'h4444, 8'h60, 8'h19},
    '{8'h08, 8'h08, 1'h1, RATE_HALF, RATE_HALF, 1'h0, 1'h1, 3'h1, 16'h0444, 16'h2444, 8'h60, 8'h32},
    '{8'h09, 8'h08, 1'h0, RATE_HALF, RATE_HALF, 1'h0, 1'h1, 3'h1, 16'h2444, 16'h0444, 8'h60, 8'h32},
    '{8'h08, 8'h10, 1'h0, RATE_HALF, RATE_HALF, 1'h1, 1'h1, 3'h2, 16'h0244, 16'h1344, 8'hc0, 8'h32},
    '{8'h0d, 8'h10, 1'h1, RATE_HALF, RATE_HALF, 1'h1, 1'h1, 3'h2, 16'h1344, 16'h0244, 8'hc0, 8'h32},
    '{8'h0a, 8'h10, 1'h0, RATE_DOUBLE, RATE_OFF, 1'h1, 1'h1, 3'h4, 16'h0123, 16'h4444, 8'hc0, 8'h32},
    '{8'h0b, 8'h08, 1'h1, RATE_SAME, RATE_SAME, 1'h0, 1'h1, 3'h2, 16'h0244, 16'h0244, 8'h60, 8'h19},
    '{8'h08, 8'h00, 1'h1, RATE_HALF, RATE_HALF, 1'h1, 1'h1, 3'h2, 16'h0244, 16'h1344, 8'hc0, 8'h32},
    '{8'h08, 8'h18, 1'h0, RATE_HALF, RATE_HALF, 1'h0, 1'h1, 3'h1, 16'h0444, 16'h2444, 8'h60, 8'h32}
  };

  lane_mode_pixel_distributor u_lane_mode_pixel_distributor (
    .clk(clk), .reset(reset), .pclk_in(pclk_in), .lane0_symbol(lane0_symbol),
    .lane1_symbol(lane1_symbol), .lane1_present(lane1_present),
    .output_mode_strap(output_mode_strap), .link_mode_strap(link_mode_strap),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .lvds_display_output(lvds_display_output), .cfg(cfg)
  );

  pixel_source u_pixel_source (.pclk(pclk_in), .sym0(lane0_symbol), .sym1(lane1_symbol));

  initial clk = 1'h0;
  always #25 clk = ~clk;

  // frames are collected as they stand, one entry per strobe
  always @(posedge clk)
    if (lvds_display_output.strobe === 1'h1)
    begin
      q_odd.push_back(lvds_display_output.odd);
      q_even.push_back(lvds_display_output.even);
    end

  // ----------
  // helpers
  // ----------
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'h1;
    @(posedge clk);
    wr <= 1'h0;
  endtask : reg_wr

  task automatic reg_rd(input logic [7:0] a, input logic [7:0] exp, input string name);
    @(posedge clk);
    addr <= a;
    rd <= 1'h1;
    @(posedge clk);
    rd <= 1'h0;
    @(posedge clk);
    chk(name, exp, rdata);
  endtask : reg_rd

  function automatic logic [FRAME_W-1:0] frame_of(input logic [SYM_W-1:0] s, input logic b24, input logic map);
    logic [7:0] rr;
    logic [7:0] gg;
    logic [7:0] bb;
    logic [1:0] m;
    rr = s[23:16];
    gg = s[15:8];
    bb = s[7:0];
    m = {2{b24}};
    if (b24 && map)
      return {1'h0, rr[7:6], gg[7:6], bb[7:6], s[26:24], bb[5:0], gg[5:0], rr[5:0]};
    return {1'h0, rr[1:0] & m, gg[1:0] & m, bb[1:0] & m, s[26:24], bb[7:2], gg[7:2], rr[7:2]};
  endfunction : frame_of

  task automatic complete_run();
    if (error_cnt == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : complete_run

  // ----------
  // tests
  // ----------
  initial
  begin
    #500000;
    error_cnt++;
    complete_run();
  end

  initial
  begin
    error_cnt = 0;
    total_checks = 0;
    reset = 1'h1;
    wr = 1'h0;
    rd = 1'h0;
    addr = 8'h00;
    wdata = 8'h00;
    lane1_present = 1'h0;
    output_mode_strap = 3'h6;
    link_mode_strap = 3'h3;
    repeat (4) @(posedge clk);
    reset <= 1'h0;
    repeat (6) @(posedge clk);
    chk("map_sel", 32'h1, cfg.map_sel);
    chk("fast_bc", 32'h1, cfg.fast_bc);
    chk("coax", 32'h1, cfg.coax);
    reg_rd(ADDR_OUT, 8'h0e, "out_reg");
    reg_rd(ADDR_LINK, 8'h0c, "link_reg");
    @(posedge clk);
    chk("rdata_idle", 32'h0, rdata);
    reg_rd(8'hf0, 8'h00, "unmapped");
    reg_wr(ADDR_PMAX, 8'h01);
    for (int lvl = 0; lvl < 8; lvl++)
    begin
      reg_wr(ADDR_LINK, 8'(lvl << 2));
      repeat (3) @(posedge clk);
      chk("fast_bc", 32'(lvl[1]), cfg.fast_bc);
      chk("coax", 32'(lvl[0]), cfg.coax);
    end
    for (int i = 0; i < 11; i++)
    begin
      r = rows[i];
      reg_wr(ADDR_OUT, r.out_val);
      reg_wr(ADDR_LANE, r.lane_val);
      lane1_present <= r.l1p;
      repeat (6) @(posedge clk);
      chk("two_lanes", r.two, cfg.two_lanes);
      chk("first_output_clock_rate", r.r1, lvds_display_output.first_output_clock_rate);
      if (r.chk2) chk("second_output_clock_rate", r.r2, lvds_display_output.second_output_clock_rate);
      chk("map_sel", r.out_val[2], cfg.map_sel);
      chk("bpp24", r.out_val[3], cfg.bpp24);
      if (r.chk2) reg_rd(ADDR_STAT, {3'h0, r.r2, r.r1, r.two}, "status");
      reg_rd(ADDR_PMAX, r.pmax, "pclk_max");
      reg_rd(ADDR_PMIN, r.pmin, "pclk_min");
      for (int k = 0; k < 4; k++)
        fr[k] = frame_of(pix[k], r.out_val[3], r.out_val[2]);
      fr[4] = 28'h0;
      u_pixel_source.send_pixel(35'h0123456, 35'h0654321);
      repeat (6) @(posedge clk);
      q_odd.delete();
      q_even.delete();
      u_pixel_source.send_pixel(pix[0], pix[1]);
      u_pixel_source.send_pixel(pix[2], pix[3]);
      repeat (8) @(posedge clk);
      chk("strobes", r.n, q_odd.size());
      for (int k = 0; k < r.n && k < q_odd.size(); k++)
      begin
        chk("odd", fr[r.od[15-4*k -: 4]], q_odd[k]);
        chk("even", fr[r.ev[15-4*k -: 4]], q_even[k]);
      end
      chk("first_output_clock_pat", CLK_PAT, lvds_display_output.first_output_clock_pat);
      if (r.chk2) chk("second_output_clock_pat", r.r2 == RATE_OFF ? 7'h00 : CLK_PAT, lvds_display_output.second_output_clock_pat);
    end
    output_mode_strap <= 3'h1;
    link_mode_strap <= 3'h4;
    reset <= 1'h1;
    repeat (4) @(posedge clk);
    reset <= 1'h0;
    repeat (6) @(posedge clk);
    reg_rd(ADDR_OUT, 8'h09, "out_strap");
    reg_rd(ADDR_LINK, 8'h10, "link_strap");
    reg_rd(ADDR_LANE, 8'h00, "lane_reg");
    chk("coax", 32'h0, cfg.coax);
    reg_wr(ADDR_OUT, 8'h0a);
    repeat (20) @(posedge clk);
    reg_rd(ADDR_OUT, 8'h0a, "out_kept");
    complete_run();
  end
endmodule : lane_mode_pixel_distributor_tb
